// File: hw/hmcsp_pkg.sv
// Purpose: constants for the homing and cyclic position mode controller
// Assumes: one 200 MHz clock, plain register port with 16-bit object index
// Notes: registers sit at their object index; 32-bit data, narrow values low
// Notes on behaviour
// - mode value 6 selects homing
// - homing search follows homing-method value
// - bit 4 rise starts, fall stops homing
// - halt brakes with homing acceleration, stays enabled
// - status bit 10: home reached or zero speed
// - status bit 12: homing completed successfully
// - status bit 13: homing error occurred
// - words 0,6,7,F walk the drive states
// - 0x001F in homing reports 0x1n37
// - mode change only while switched on; code refuses it only in operation enabled
// - mode bits act only when operation enabled
// - homing ramp times from parameter 1135
// - mode value 8 selects cyclic position
// - cyclic target taken at each interval
// - cyclic mode uses only low four bits
// - cyclic status: 12 reference used, 13 following error
// - no ramp limiting in cyclic mode
// - 0xnnnF to 0x0007 stops the mode
package hmcsp_pkg;
	// object indices used as register addresses
	localparam logic [15:0] HMCSP_IDX_CTRL     = 16'h6040;
	localparam logic [15:0] HMCSP_IDX_STAT     = 16'h6041;
	localparam logic [15:0] HMCSP_IDX_MODE     = 16'h6060;
	localparam logic [15:0] HMCSP_IDX_MODE_DSP = 16'h6061;
	localparam logic [15:0] HMCSP_IDX_ACT_POS  = 16'h6064;
	localparam logic [15:0] HMCSP_IDX_TGT_POS  = 16'h607A;
	localparam logic [15:0] HMCSP_IDX_HM_METH  = 16'h6098;
	localparam logic [15:0] HMCSP_IDX_HM_ACC   = 16'h609A;
	localparam logic [15:0] HMCSP_IDX_HM_RAMP  = 16'h2000;
	// mode select values
	localparam logic [7:0] HMCSP_MODE_HOMING = 8'h06;
	localparam logic [7:0] HMCSP_MODE_CSP    = 8'h08;
	// control word bit positions
	localparam int HMCSP_CW_VOLT  = 1;
	localparam int HMCSP_CW_QSTOP = 2;
	localparam int HMCSP_CW_ENOP  = 3;
	localparam int HMCSP_CW_HSTRT = 4;
	localparam int HMCSP_CW_HALT  = 8;
	// status word bit positions
	localparam int HMCSP_SW_GOAL = 10;
	localparam int HMCSP_SW_M12  = 12;
	localparam int HMCSP_SW_M13  = 13;
	// control commands on the low nibble
	localparam logic [3:0] HMCSP_NIB_SWON = 4'h7;
	localparam logic [3:0] HMCSP_NIB_ENOP = 4'hF;
	localparam logic [2:0] HMCSP_TRI_SHUT = 3'h6;
	// base status words per drive state
	localparam logic [15:0] HMCSP_SW_DISABLED = 16'h0050;
	localparam logic [15:0] HMCSP_SW_READY    = 16'h0031;
	localparam logic [15:0] HMCSP_SW_SWON     = 16'h0033;
	localparam logic [15:0] HMCSP_SW_OPEN     = 16'h0037;
	// reset values
	localparam logic [15:0] HMCSP_CTRL_RST = 16'h0000;
	localparam logic [7:0]  HMCSP_MODE_RST = 8'h00;
	localparam logic [31:0] HMCSP_ZERO32   = 32'h00000000;
	// drive state machine
	typedef enum logic [1:0] {
		HMCSP_ST_DISABLED = 2'b00,
		HMCSP_ST_READY    = 2'b01,
		HMCSP_ST_SWON     = 2'b10,
		HMCSP_ST_OPEN     = 2'b11
	} hmcsp_state_e;
endpackage

// File: hw/hmcsp_ctrl.sv
// Purpose: control word decode and status word report for homing and
//          cyclic synchronous position modes
// Assumes: all inputs but the async rst_in synchronous to ref_clk_in; motion core outside
// Notes: read data valid the cycle after the read strobe, and only then
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module hmcsp_ctrl #(
	parameter int DATA_W = 32
) (
	input  wire logic                       ref_clk_in,      // 200 MHz
	input  wire logic                       rst_in,          // async, high
	input  wire logic [15:0]                addr_in,         // object index
	input  wire logic [DATA_W-1:0]          wr_data_in,      // write data
	input  wire logic                       wr_in,           // write strobe
	input  wire logic                       rd_in,           // read strobe
	output logic      [DATA_W-1:0]          rd_data_out,     // read data
	input  wire logic                       home_found_in,   // home reached
	input  wire logic                       zero_speed_in,   // axle stopped
	input  wire logic                       homing_done_in,  // search ended ok
	input  wire logic                       homing_fail_in,  // search failed
	input  wire logic                       follow_err_in,   // following error
	input  wire logic                       sync_tick_in,    // cyclic interval
	input  wire logic [DATA_W-1:0]          actual_pos_in,   // position now
	output logic                            power_on_out,    // bridge enabled
	output logic                            homing_run_out,  // run search
	output logic                            halt_brake_out,  // brake axis
	output logic      [7:0]                 homing_meth_out, // search method
	output logic      [DATA_W-1:0]          homing_acc_out,  // accel/decel
	output logic      [DATA_W-1:0]          homing_ramp_out, // ramp times
	output logic                            csp_run_out,     // follow target
	output logic      [DATA_W-1:0]          pos_ref_out,     // reference
	output logic                            pos_ref_stb_out, // new reference
	output logic      [15:0]                status_out       // status word
);
	import hmcsp_pkg::*;

	// software visible registers
	logic [15:0]        ctrl_q;        // control word
	logic [7:0]         mode_q;        // mode select
	logic [DATA_W-1:0]  tgt_q;         // target position
	logic [7:0]         meth_q;        // homing method
	logic [DATA_W-1:0]  acc_q;         // homing acceleration
	logic [DATA_W-1:0]  ramp_q;        // homing ramp times
	// internal state
	hmcsp_state_e       state_q;       // drive state
	hmcsp_state_e       state_d;
	logic               start_prev_q;  // bit 4 one cycle back
	logic               hm_run_q;      // homing search running
	logic               hm_att_q;      // homing attained
	logic               hm_err_q;      // homing error
	logic               csp_run_q;     // following target
	logic [DATA_W-1:0]  pos_ref_q;     // current reference
	logic               ref_stb_q;     // reference update pulse
	logic [15:0]        status_q;      // status word
	logic [15:0]        status_d;
	logic [DATA_W-1:0]  rd_q;          // read data
	logic               power_q;       // power stage on
	logic               brake_q;       // halt braking
	// decoded conditions
	logic               is_open;
	logic               in_homing;
	logic               in_csp;
	logic               hm_rise;
	logic               hm_fall;
	logic               halt_req;

	assign is_open   = (state_q == HMCSP_ST_OPEN);
	assign in_homing = is_open && (mode_q == HMCSP_MODE_HOMING);
	assign in_csp    = is_open && (mode_q == HMCSP_MODE_CSP);
	assign hm_rise   = in_homing && ctrl_q[HMCSP_CW_HSTRT] && !start_prev_q;
	assign hm_fall   = !ctrl_q[HMCSP_CW_HSTRT] && start_prev_q;
	assign halt_req  = in_homing && ctrl_q[HMCSP_CW_HALT];

	// control word store; strobes never overlap so no priority needed
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q <= HMCSP_CTRL_RST;
		end else if (wr_in && addr_in == HMCSP_IDX_CTRL) begin
			ctrl_q <= wr_data_in[15:0];
		end
	end

	// mode select write
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_q <= HMCSP_MODE_RST;
		end else if (wr_in && addr_in == HMCSP_IDX_MODE && !is_open) begin
			mode_q <= wr_data_in[7:0];
		end
	end

	// parameter registers for the motion core
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tgt_q  <= HMCSP_ZERO32[DATA_W-1:0];
			meth_q <= HMCSP_MODE_RST;
			acc_q  <= HMCSP_ZERO32[DATA_W-1:0];
			ramp_q <= HMCSP_ZERO32[DATA_W-1:0];
		end else if (wr_in) begin
			if (addr_in == HMCSP_IDX_TGT_POS) begin
				tgt_q <= wr_data_in;
			end else if (addr_in == HMCSP_IDX_HM_METH) begin
				meth_q <= wr_data_in[7:0];
			end else if (addr_in == HMCSP_IDX_HM_ACC) begin
				acc_q <= wr_data_in;
			end else if (addr_in == HMCSP_IDX_HM_RAMP) begin
				ramp_q <= wr_data_in;
			end
		end
	end

	// drive state decode from the low nibble only
	always_comb begin
		state_d = state_q;
		if (!ctrl_q[HMCSP_CW_VOLT] || !ctrl_q[HMCSP_CW_QSTOP]) begin
			state_d = HMCSP_ST_DISABLED;
		end else begin
			case (state_q)
				HMCSP_ST_DISABLED: begin
					if (ctrl_q[2:0] == HMCSP_TRI_SHUT) begin
						state_d = HMCSP_ST_READY;
					end
				end
				HMCSP_ST_READY: begin
					if (ctrl_q[3:0] == HMCSP_NIB_SWON) begin
						state_d = HMCSP_ST_SWON;
					end
				end
				HMCSP_ST_SWON: begin
					if (ctrl_q[3:0] == HMCSP_NIB_ENOP) begin
						state_d = HMCSP_ST_OPEN;
					end else if (ctrl_q[2:0] == HMCSP_TRI_SHUT) begin
						state_d = HMCSP_ST_READY;
					end
				end
				default: begin
					if (ctrl_q[3:0] == HMCSP_NIB_SWON) begin
						state_d = HMCSP_ST_SWON;
					end else if (ctrl_q[2:0] == HMCSP_TRI_SHUT) begin
						state_d = HMCSP_ST_READY;
					end
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= HMCSP_ST_DISABLED;
		end else begin
			state_q <= state_d;
		end
	end

	// bit 4 history for edge detection
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			start_prev_q <= 1'b0;
		end else begin
			start_prev_q <= ctrl_q[HMCSP_CW_HSTRT];
		end
	end

	// homing run: leaving enable or mode kills it at once
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hm_run_q <= 1'b0;
		end else if (!in_homing) begin
			hm_run_q <= 1'b0;
		end else if (hm_rise) begin
			hm_run_q <= 1'b1;
		end else if (hm_fall || homing_done_in || homing_fail_in) begin
			hm_run_q <= 1'b0;
		end
	end

	// homing result flags; a result in the start cycle wins over the clear
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hm_att_q <= 1'b0;
			hm_err_q <= 1'b0;
		end else begin
			if (hm_run_q && homing_done_in) begin
				hm_att_q <= 1'b1;
			end else if (hm_rise) begin
				hm_att_q <= 1'b0;
			end
			if (hm_run_q && homing_fail_in) begin
				hm_err_q <= 1'b1;
			end else if (hm_rise) begin
				hm_err_q <= 1'b0;
			end
		end
	end

	// cyclic follow enable and reference capture
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			csp_run_q <= 1'b0;
			pos_ref_q <= HMCSP_ZERO32[DATA_W-1:0];
			ref_stb_q <= 1'b0;
		end else begin
			csp_run_q <= in_csp;
			ref_stb_q <= 1'b0;
			// target taken each interval; no ramp, see below
			if (in_csp && csp_run_q && sync_tick_in) begin
				pos_ref_q <= tgt_q;
				ref_stb_q <= 1'b1;
			end else if (!in_csp) begin
				// hold the axis where it is; master must preload target
				pos_ref_q <= actual_pos_in;
			end
		end
	end

	// reference passes unramped
	// motion dynamics are the master's job; nothing here limits steps

	// power stage and braking
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			power_q <= 1'b0;
			brake_q <= 1'b0;
		end else begin
			power_q <= is_open;
			brake_q <= hm_run_q && halt_req;
		end
	end

	// status word assembly
	always_comb begin
		status_d = HMCSP_SW_DISABLED;
		case (state_q)
			HMCSP_ST_DISABLED: status_d = HMCSP_SW_DISABLED;
			HMCSP_ST_READY:    status_d = HMCSP_SW_READY;
			HMCSP_ST_SWON:     status_d = HMCSP_SW_SWON;
			default:           status_d = HMCSP_SW_OPEN;
		endcase
		if (in_homing) begin
			// goal flag meaning depends on halt
			status_d[HMCSP_SW_GOAL] = halt_req ? zero_speed_in : home_found_in;
			status_d[HMCSP_SW_M12] = hm_att_q;
			status_d[HMCSP_SW_M13] = hm_err_q;
		end else if (in_csp) begin
			status_d[HMCSP_SW_M12] = csp_run_q;
			status_d[HMCSP_SW_M13] = follow_err_in;
		end
	end

	// status register
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			status_q <= HMCSP_SW_DISABLED;
		end else begin
			status_q <= status_d;
		end
	end

	// read mux; unmapped indices read zero
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_q <= HMCSP_ZERO32[DATA_W-1:0];
		end else if (rd_in) begin
			if (addr_in == HMCSP_IDX_CTRL) begin
				rd_q <= {{(DATA_W-16){1'b0}}, ctrl_q};
			end else if (addr_in == HMCSP_IDX_STAT) begin
				rd_q <= {{(DATA_W-16){1'b0}}, status_q};
			end else if (addr_in == HMCSP_IDX_MODE) begin
				rd_q <= {{(DATA_W-8){1'b0}}, mode_q};
			end else if (addr_in == HMCSP_IDX_MODE_DSP) begin
				rd_q <= {{(DATA_W-8){1'b0}}, is_open ? mode_q : HMCSP_MODE_RST};
			end else if (addr_in == HMCSP_IDX_ACT_POS) begin
				rd_q <= actual_pos_in;
			end else if (addr_in == HMCSP_IDX_TGT_POS) begin
				rd_q <= tgt_q;
			end else if (addr_in == HMCSP_IDX_HM_METH) begin
				rd_q <= {{(DATA_W-8){1'b0}}, meth_q};
			end else if (addr_in == HMCSP_IDX_HM_ACC) begin
				rd_q <= acc_q;
			end else if (addr_in == HMCSP_IDX_HM_RAMP) begin
				rd_q <= ramp_q;
			end else begin
				rd_q <= HMCSP_ZERO32[DATA_W-1:0];
			end
		end else begin
			rd_q <= HMCSP_ZERO32[DATA_W-1:0];
		end
	end

	// outputs straight from flops, homing_run_out masked by brake_q
	assign rd_data_out     = rd_q;
	assign power_on_out    = power_q;
	assign homing_run_out  = hm_run_q && !brake_q;
	assign halt_brake_out  = brake_q;
	assign homing_meth_out = meth_q;
	assign homing_acc_out  = acc_q;
	assign homing_ramp_out = ramp_q;
	assign csp_run_out     = csp_run_q;
	assign pos_ref_out     = pos_ref_q;
	assign pos_ref_stb_out = ref_stb_q;
	assign status_out      = status_q;

	// checks on the decode and status paths
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	property p_homing_start;
		hm_rise |=> hm_run_q;
	endproperty
	a_homing_start: assert property (p_homing_start)
		else $error("homing did not start on bit 4 rise");

	property p_homing_stop;
		hm_fall |=> !hm_run_q;
	endproperty
	a_homing_stop: assert property (p_homing_stop)
		else $error("homing did not stop on bit 4 fall");

	property p_flags_clear;
		hm_rise && !hm_run_q |=> !hm_att_q && !hm_err_q;
	endproperty
	a_flags_clear: assert property (p_flags_clear)
		else $error("homing result flags not cleared on start");

	property p_halt_brake;
		hm_run_q && halt_req |=> halt_brake_out ##1 power_on_out;
	endproperty
	a_halt_brake: assert property (p_halt_brake)
		else $error("halt did not brake while staying enabled");

	property p_goal_bit;
		in_homing |=> status_out[HMCSP_SW_GOAL] ==
			($past(halt_req) ? $past(zero_speed_in) : $past(home_found_in));
	endproperty
	a_goal_bit: assert property (p_goal_bit)
		else $error("status bit 10 wrong in homing");

	property p_attained;
		hm_run_q && homing_done_in && in_homing |=> ##1 status_out[HMCSP_SW_M12];
	endproperty
	a_attained: assert property (p_attained)
		else $error("homing attained not reported");

	property p_mode_locked;
		wr_in && addr_in == HMCSP_IDX_MODE && is_open |=> $stable(mode_q);
	endproperty
	a_mode_locked: assert property (p_mode_locked)
		else $error("mode changed while operation enabled");

	property p_csp_sample;
		in_csp && csp_run_q && sync_tick_in |=> pos_ref_out == $past(tgt_q) && pos_ref_stb_out;
	endproperty
	a_csp_sample: assert property (p_csp_sample)
		else $error("cyclic target not taken on interval");

	property p_shutdown;
		state_q == HMCSP_ST_DISABLED && ctrl_q == 16'(HMCSP_TRI_SHUT) |=> ##1
			status_out == HMCSP_SW_READY;
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("shutdown did not reach ready to switch on");

	property p_enable_only;
		!is_open |=> !hm_run_q && !csp_run_q;
	endproperty
	a_enable_only: assert property (p_enable_only)
		else $error("mode ran outside operation enabled");
endmodule
`default_nettype wire

// File: bench/hmcsp_motion_model.sv
// Purpose: motion core stand-in behind the controller outputs
// Assumes: one clock; homing search takes DLY cycles of active running
// Notes: fail_mode_in picks whether the search ends well or badly
`timescale 1ns/1ps
`default_nettype none
module hmcsp_motion_model #(
	parameter int          DLY  = 12,           // search length in cycles
	parameter int          TICK = 16,           // cyclic interval in cycles
	parameter logic [31:0] POS0 = 32'h00001234  // start position, plain value
) (
	input  wire logic        clk_in,          // drive clock
	input  wire logic        rst_in,          // async, high
	input  wire logic        homing_run_in,   // search active
	input  wire logic        halt_brake_in,   // braking
	input  wire logic        fail_mode_in,    // end search in error
	input  wire logic        pos_ref_stb_in,  // new reference
	input  wire logic [31:0] pos_ref_in,      // reference value
	output logic             home_found_out,  // home reached
	output logic             zero_speed_out,  // axle stopped
	output logic             done_out,        // search ended ok
	output logic             fail_out,        // search failed
	output logic             sync_tick_out,   // cyclic interval pulse
	output logic      [31:0] actual_pos_out   // position now
);
	logic [7:0] cnt_q;   // cycles of running search
	logic [7:0] tick_q;  // interval counter

	// search progress, dropped when the run stops
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 8'h00;
		end else if (homing_run_in) begin
			cnt_q <= cnt_q + 8'h01;
		end else begin
			cnt_q <= 8'h00;
		end
	end
	assign done_out = homing_run_in && (cnt_q == 8'(DLY)) && !fail_mode_in;
	assign fail_out = homing_run_in && (cnt_q == 8'(DLY)) && fail_mode_in;

	// home flag held after success, cleared as a new search starts
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			home_found_out <= 1'b0;
		end else if (done_out) begin
			home_found_out <= 1'b1;
		end else if (cnt_q == 8'h01) begin
			home_found_out <= 1'b0;
		end
	end

	// axle needs a cycle to come to rest under the brake
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			zero_speed_out <= 1'b0;
		end else begin
			zero_speed_out <= halt_brake_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_q <= 8'h00;
		end else begin
			tick_q <= (tick_q == 8'(TICK - 1)) ? 8'h00 : tick_q + 8'h01;
		end
	end
	assign sync_tick_out = (tick_q == 8'h00) && !rst_in;

	// position jumps straight to the reference, no ramp
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			actual_pos_out <= POS0;
		end else if (pos_ref_stb_in) begin
			actual_pos_out <= pos_ref_in;
		end
	end
endmodule
`default_nettype wire

// File: bench/homing_csp_mode_control_tb_top.sv
// Purpose: register-level tests of homing and cyclic position control
// Assumes: bus tasks keep one-cycle strobes; 200 MHz clock
// Notes: control writes are followed by a settle of four cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module homing_csp_mode_control_tb_top;
	import hmcsp_pkg::*;
	localparam int          TICK = 16;            // cyclic interval
	localparam logic [31:0] POS0 = 32'h00001234;  // model start position
	logic        ref_clk_in = 1'b0;   // clock
	logic        rst_in     = 1'b1;   // reset
	logic        wr_in      = 1'b0;   // write strobe
	logic        rd_in      = 1'b0;   // read strobe
	logic        fail_mode  = 1'b0;   // model ends search badly
	logic        follow_err = 1'b0;   // following error level
	logic [15:0] addr       = 16'h0000;
	logic [31:0] wdata      = 32'h00000000;
	logic [31:0] rd_data, pos_ref, act_pos, acc, ramp, v;
	logic [15:0] status;
	logic [7:0]  meth;
	logic        found, zspd, done, fail, tick, pwr, hrun, brake, crun, stb;
	int          failures = 0;
	int          compares = 0;
	int          cycles   = 0;

	// free-running 5 ns clock
	always #2.5 ref_clk_in = ~ref_clk_in;

	hmcsp_ctrl #(.DATA_W(32)) u_hmcsp_ctrl (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr),
		.wr_data_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data),
		.home_found_in(found), .zero_speed_in(zspd), .homing_done_in(done),
		.homing_fail_in(fail), .follow_err_in(follow_err), .sync_tick_in(tick),
		.actual_pos_in(act_pos), .power_on_out(pwr), .homing_run_out(hrun),
		.halt_brake_out(brake), .homing_meth_out(meth), .homing_acc_out(acc),
		.homing_ramp_out(ramp), .csp_run_out(crun), .pos_ref_out(pos_ref),
		.pos_ref_stb_out(stb), .status_out(status));

	hmcsp_motion_model #(.TICK(TICK), .POS0(POS0)) u_hmcsp_motion_model (
		.clk_in(ref_clk_in), .rst_in(rst_in), .homing_run_in(hrun),
		.halt_brake_in(brake), .fail_mode_in(fail_mode), .pos_ref_stb_in(stb),
		.pos_ref_in(pos_ref), .home_found_out(found), .zero_speed_out(zspd),
		.done_out(done), .fail_out(fail), .sync_tick_out(tick),
		.actual_pos_out(act_pos));

	// verdict and end of run, shared by main sequence and timeout
	task automatic results();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		addr  <= a;
		wdata <= d;
		wr_in <= 1'b1;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge ref_clk_in);
		addr  <= a;
		rd_in <= 1'b1;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		// taken at the edge that closes the data cycle, so later drives stay on edges
		@(posedge ref_clk_in);
		d = rd_data;
	endtask

	task automatic chk_rd(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask

	// control word write, then let state and status settle
	task automatic ctl(input logic [15:0] d);
		wr(HMCSP_IDX_CTRL, {16'h0000, d});
		cyc(4);
	endtask

	// hang guard, the whole run needs well under 1000 cycles
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			results();
		end
	end

	initial begin
		cyc(3);
		rst_in <= 1'b0;
		chk_rd(HMCSP_IDX_STAT, 32'h00000050);
		chk_rd(16'h1234, 32'h00000000);
		wr(HMCSP_IDX_MODE, 32'h00000006);
		wr(HMCSP_IDX_HM_METH, 32'h00000023);
		wr(HMCSP_IDX_HM_ACC, 32'h00001000);
		wr(HMCSP_IDX_HM_RAMP, 32'h00000500);
		cyc(2);
		`CHK(meth, 8'h23)
		`CHK(acc, 32'h00001000)
		`CHK(ramp, 32'h00000500)
		ctl(16'h0006);
		chk_rd(HMCSP_IDX_STAT, 32'h00000031);
		ctl(16'h0007);
		chk_rd(HMCSP_IDX_STAT, 32'h00000033);
		// start bit without enable must not move the axis
		ctl(16'h0017);
		`CHK(hrun, 1'b0)
		ctl(16'h000F);
		chk_rd(HMCSP_IDX_STAT, 32'h00000037);
		chk_rd(HMCSP_IDX_MODE_DSP, 32'h00000006);
		// mode change while enabled is refused
		wr(HMCSP_IDX_MODE, 32'h00000008);
		chk_rd(HMCSP_IDX_MODE, 32'h00000006);
		ctl(16'h001F);
		`CHK(hrun, 1'b1)
		cyc(16);
		rd(HMCSP_IDX_STAT, v);
		`CHK({v[15:12], v[7:0]}, 12'h137)
		`CHK(v[13:12], 2'b01)
		`CHK(v[10], 1'b1)
		// failing search after a restart
		fail_mode <= 1'b1;
		ctl(16'h000F);
		ctl(16'h001F);
		rd(HMCSP_IDX_STAT, v);
		`CHK(v[13:12], 2'b00)
		cyc(14);
		rd(HMCSP_IDX_STAT, v);
		`CHK(v[13:12], 2'b10)
		// halt in mid-search
		fail_mode <= 1'b0;
		ctl(16'h000F);
		ctl(16'h001F);
		ctl(16'h011F);
		`CHK(brake, 1'b1)
		`CHK(hrun, 1'b0)
		`CHK(pwr, 1'b1)
		rd(HMCSP_IDX_STAT, v);
		`CHK(v[10], 1'b1)
		ctl(16'h0007);
		`CHK(pwr, 1'b0)
		chk_rd(HMCSP_IDX_STAT, 32'h00000033);
		// master confirms switched on before touching the mode
		chk_rd(HMCSP_IDX_STAT, 32'h00000033);
		// cyclic mode with preloaded target
		wr(HMCSP_IDX_MODE, 32'h00000008);
		rd(HMCSP_IDX_ACT_POS, v);
		`CHK(v, POS0)
		wr(HMCSP_IDX_TGT_POS, v);
		ctl(16'h000F);
		rd(HMCSP_IDX_STAT, v);
		`CHK(v[13:12], 2'b01)
		// target updates only once bit 12 is seen
		`CHK(v[12], 1'b1)
		chk_rd(HMCSP_IDX_MODE_DSP, 32'h00000008);
		wr(HMCSP_IDX_TGT_POS, 32'h0000BEEF);
		cyc(TICK + 4);
		`CHK(pos_ref, 32'h0000BEEF)
		// model only moves on the strobe, so this proves the pulse
		chk_rd(HMCSP_IDX_ACT_POS, 32'h0000BEEF);
		// upper control bits are ignored here
		ctl(16'hFF1F);
		`CHK(hrun, 1'b0)
		`CHK(crun, 1'b1)
		follow_err <= 1'b1;
		cyc(3);
		`CHK(status[13], 1'b1)
		results();
	end
endmodule
`default_nettype wire
